// *** rtl/uit_uart_irq.sv ***
// UART interrupt, programmable transmit threshold and shadow registers,
// reached over AXI4-Lite. Assumes the serial side runs on aclk: it pushes
// received characters with flags and pops transmit characters.
`timescale 1ns/100ps
`default_nettype none
`include "uit_defines.svh"
module uit_uart_irq #(
	parameter int FIFO_DEPTH = 16,   // Characters per FIFO
	parameter int CHAR_BITS  = 10    // Bits per character on the line
) (
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	input  wire logic                     ce,
	input  wire logic [`UIT_AW-1:0]       awaddr,
	input  wire logic                     awvalid,
	output logic                          awready,
	input  wire logic [31:0]              wdata,
	input  wire logic [3:0]               wstrb,
	input  wire logic                     wvalid,
	output logic                          wready,
	output uit_pkg::uit_resp_t            bresp,
	output logic                          bvalid,
	input  wire logic                     bready,
	input  wire logic [`UIT_AW-1:0]       araddr,
	input  wire logic                     arvalid,
	output logic                          arready,
	output logic [31:0]                   rdata,
	output uit_pkg::uit_resp_t            rresp,
	output logic                          rvalid,
	input  wire logic                     rready,
	input  wire logic                     rx_valid,
	input  wire uit_pkg::uit_byte_t       rx_data,
	input  wire logic                     rx_parity_err,
	input  wire logic                     rx_frame_err,
	input  wire logic                     rx_break,
	output logic                          tx_valid,
	output uit_pkg::uit_byte_t            tx_data,
	input  wire logic                     tx_ready,
	input  wire logic                     tx_idle,
	input  wire logic                     baud_tick,
	output logic                          irq
);
	import uit_pkg::*;

	localparam int CW        = $clog2(FIFO_DEPTH + 1);
	// Four character times counted in baud ticks
	localparam int TMO_TICKS = `UIT_TMO_CHARS * CHAR_BITS
		* `UIT_BAUD_PER_BIT;
	localparam int TW        = $clog2(TMO_TICKS + 1);

	uit_fifo_if #(.W(8), .DEPTH(FIFO_DEPTH)) rxf ();  // Receive FIFO
	uit_fifo_if #(.W(8), .DEPTH(FIFO_DEPTH)) txf ();  // Transmit FIFO

	// Receive and transmit storage; both freeze with the clock enable
	uit_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.f       (rxf)
	);
	uit_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.f       (txf)
	);

	// Software state
	uit_byte_t        irq_enable_reg;           // Interrupt enables
	uit_byte_t        fifo_control_reg;           // FIFO control
	logic [3:0]       err;           // Sticky {break, frame, parity, overrun}
	logic             tx_holding_empty_pend;     // Transmit-empty event pending
	logic             tx_holding_empty_cond_q;   // Previous transmit-empty level
	logic             tx_holding_empty_en_q;     // Previous transmit enable
	logic [TW-1:0]    tmo_cnt;       // Baud ticks since receive activity
	logic             irq_q;         // Registered interrupt
	// Bus state
	logic             aw_held;       // Write address taken
	logic [`UIT_AW-1:0] aw_addr;     // Its value
	logic             w_held;        // Write data taken
	uit_byte_t        w_byte;        // Low byte of write data
	logic             w_lane0;       // Low byte lane enabled
	logic             bvalid_q;
	uit_resp_t        bresp_q;
	logic             rvalid_q;
	logic [31:0]      rdata_q;
	uit_resp_t        rresp_q;
	// Next values
	uit_byte_t        next_ier;
	uit_byte_t        next_fcr;
	logic [3:0]       next_err;
	logic             next_tx_holding_empty_pend;
	logic [TW-1:0]    next_tmo_cnt;
	logic             next_aw_held;
	logic [`UIT_AW-1:0] next_aw_addr;
	logic             next_w_held;
	uit_byte_t        next_w_byte;
	logic             next_w_lane0;
	logic             next_bvalid;
	uit_resp_t        next_bresp;
	logic             next_rvalid;
	logic [31:0]      next_rdata;
	uit_resp_t        next_rresp;
	// Decoded and derived terms
	uit_reg_e         wr_sel;        // Register written
	uit_reg_e         rd_sel;        // Register read
	logic             do_wr;         // Write performed this cycle
	logic             do_rd;         // Read taken this cycle
	logic             fifo_en;       // FIFOs enabled
	logic             prog_mode;     // Threshold mode in force
	logic [CW-1:0]    tet_level;     // Transmit threshold level
	logic [CW-1:0]    rt_level;      // Receive trigger level
	logic             rx_full_eff;   // No room for a received character
	logic             tx_full_eff;   // No room for a transmit character
	logic             tx_holding_empty_cond;     // Transmit-empty level
	logic             rda_cond;      // Receive data condition
	logic             tmo_cond;      // Character timeout condition
	uit_byte_t        line_status_reg;           // Line status view
	uit_id_t          id;            // Current identification code
	logic             line_act;
	logic             rda_act;
	logic             tmo_act;
	logic             tx_holding_empty_act;

	// Map a byte address to a register; shadow words alias the data port
	function automatic uit_reg_e decode(input logic [`UIT_AW-1:0] a);
		logic [`UIT_AW-1:0] w;
		w = {a[`UIT_AW-1:2], 2'b00};
		if (w == `UIT_OFF_DATA)
			return REG_DATA;
		if (w >= `UIT_OFF_SHADOW_LO && w <= `UIT_OFF_SHADOW_HI)
			return REG_DATA;
		if (w == `UIT_OFF_IER)
			return REG_IER;
		if (w == `UIT_OFF_IIR)
			return REG_IIR;
		if (w == `UIT_OFF_LSR)
			return REG_LSR;
		if (w == `UIT_OFF_SFE)
			return REG_SFE;
		if (w == `UIT_OFF_SRT)
			return REG_SRT;
		if (w == `UIT_OFF_STER)
			return REG_STER;
		return REG_NONE;
	endfunction

	// Bus handshakes; nothing is taken while the clock enable is low
	assign awready = ce && !aw_held && !bvalid_q;
	assign wready  = ce && !w_held && !bvalid_q;
	assign arready = ce && !rvalid_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign rvalid  = rvalid_q;
	assign rdata   = rdata_q;
	assign rresp   = rresp_q;
	assign do_wr   = ce && aw_held && w_held && !bvalid_q;
	assign do_rd   = arvalid && arready;
	assign wr_sel  = decode(aw_addr);
	assign rd_sel  = decode(araddr);

	// Mode and level terms
	always_comb
	begin
		fifo_en   = fifo_control_reg[`UIT_FCR_EN];
		prog_mode = irq_enable_reg[`UIT_IER_PROG] && fifo_en;
		case (fifo_control_reg[`UIT_FCR_TET_HI:`UIT_FCR_TET_LO])
			`UIT_SEL_0: tet_level = '0;
			`UIT_SEL_1: tet_level = CW'(`UIT_TET_TWO_LEVEL);
			`UIT_SEL_2: tet_level = CW'(FIFO_DEPTH / 4);
			default:    tet_level = CW'(FIFO_DEPTH / 2);
		endcase
		case (fifo_control_reg[`UIT_FCR_RT_HI:`UIT_FCR_RT_LO])
			`UIT_SEL_0: rt_level = CW'(1);
			`UIT_SEL_1: rt_level = CW'(FIFO_DEPTH / 4);
			`UIT_SEL_2: rt_level = CW'(FIFO_DEPTH / 2);
			default:    rt_level = CW'(FIFO_DEPTH - `UIT_RT_FULL_GAP);
		endcase
		// Without FIFOs each side holds a single character
		rx_full_eff = fifo_en ? rxf.full : !rxf.empty;
		tx_full_eff = fifo_en ? txf.full : !txf.empty;
		if (prog_mode)
			tx_holding_empty_cond = (txf.count <= tet_level);
		else
			tx_holding_empty_cond = txf.empty;
		rda_cond = fifo_en ? (rxf.count >= rt_level)
			: !rxf.empty;
		tmo_cond = fifo_en && !rxf.empty
			&& (tmo_cnt == TW'(TMO_TICKS));
	end

	// Line status view
	always_comb
	begin
		line_status_reg                = '0;
		line_status_reg[`UIT_LSR_DR]   = !rxf.empty;
		line_status_reg[`UIT_LSR_OE]   = err[0];
		line_status_reg[`UIT_LSR_PE]   = err[1];
		line_status_reg[`UIT_LSR_FE]   = err[2];
		line_status_reg[`UIT_LSR_BI]   = err[3];
		// Full in threshold mode, empty otherwise
		line_status_reg[`UIT_LSR_TX_HOLDING_EMPTY] = prog_mode ? txf.full
			: txf.empty;
		line_status_reg[`UIT_LSR_TEMT] = txf.empty && tx_idle;
		line_status_reg[`UIT_LSR_RFE]  = fifo_en && |err[3:1];
	end

	// Enabled active sources and their priority
	assign line_act = irq_enable_reg[`UIT_IER_LINE] && |err;
	assign rda_act  = irq_enable_reg[`UIT_IER_RDA] && rda_cond;
	assign tmo_act  = irq_enable_reg[`UIT_IER_RDA] && tmo_cond;
	assign tx_holding_empty_act = irq_enable_reg[`UIT_IER_TX_HOLDING_EMPTY] && tx_holding_empty_pend;

	uit_irq_prio u_prio (
		.line_act (line_act),
		.rda_act  (rda_act),
		.tmo_act  (tmo_act),
		.tx_holding_empty_act (tx_holding_empty_act),
		.id       (id)
	);

	// FIFO connections and bus side effects on them
	always_comb
	begin
		rxf.push      = rx_valid && !rx_full_eff;
		rxf.push_data = rx_data;
		rxf.pop       = do_rd && rd_sel == REG_DATA;
		rxf.flush     = do_wr && (wr_sel == REG_IIR || wr_sel == REG_SFE)
			&& w_lane0 && (w_byte[`UIT_FCR_RXRST]
			|| w_byte[`UIT_FCR_EN] != fifo_en);
		txf.push      = do_wr && wr_sel == REG_DATA && w_lane0
			&& !tx_full_eff;
		txf.push_data = w_byte;
		txf.pop       = tx_valid && tx_ready;
		txf.flush     = do_wr && (wr_sel == REG_IIR || wr_sel == REG_SFE)
			&& w_lane0 && ((wr_sel == REG_IIR && w_byte[`UIT_FCR_TXRST])
			|| w_byte[`UIT_FCR_EN] != fifo_en);
	end
	assign tx_valid = !txf.empty;
	assign tx_data  = txf.pop_data;

	// Next values of registers, flags and bus state
	always_comb
	begin
		next_ier      = irq_enable_reg;
		next_fcr      = fifo_control_reg;
		next_aw_held  = aw_held;
		next_aw_addr  = aw_addr;
		next_w_held   = w_held;
		next_w_byte   = w_byte;
		next_w_lane0  = w_lane0;
		next_bvalid   = bvalid_q && !bready;
		next_bresp    = bresp_q;
		next_rvalid   = rvalid_q && !rready;
		next_rdata    = rdata_q;
		next_rresp    = rresp_q;
		if (awvalid && awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = awaddr;
		end
		if (wvalid && wready)
		begin
			next_w_held  = 1'b1;
			next_w_byte  = wdata[7:0];
			next_w_lane0 = wstrb[0];
		end
		// Register writes once address and data are both held
		if (do_wr)
		begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (wr_sel == REG_NONE) ? `UIT_RESP_SLVERR
				: `UIT_RESP_OKAY;
			if (w_lane0)
			begin
				case (wr_sel)
					REG_IER:  next_ier = w_byte;
					REG_IIR:  next_fcr = w_byte;
					REG_SFE:  next_fcr[`UIT_FCR_EN] =
						w_byte[0];
					REG_SRT:  next_fcr[`UIT_FCR_RT_HI:`UIT_FCR_RT_LO] =
						w_byte[1:0];
					REG_STER: next_fcr[`UIT_FCR_TET_HI:`UIT_FCR_TET_LO] =
						w_byte[1:0];
					default:  next_ier = irq_enable_reg;
				endcase
			end
			// Reset bits act once and are not stored
			next_fcr[`UIT_FCR_RXRST] = 1'b0;
			next_fcr[`UIT_FCR_TXRST] = 1'b0;
		end
		// Register reads
		if (do_rd)
		begin
			next_rvalid = 1'b1;
			next_rresp  = `UIT_RESP_OKAY;
			next_rdata  = '0;
			case (rd_sel)
				REG_DATA: next_rdata[7:0] = rxf.empty ? '0 : rxf.pop_data;
				REG_IER:  next_rdata[7:0] = irq_enable_reg;
				REG_IIR:  next_rdata[7:0] = {fifo_en ? `UIT_IIR_FIFO_ON
					: `UIT_IIR_FIFO_OFF, 2'b00, id};
				REG_LSR:  next_rdata[7:0] = line_status_reg;
				REG_SFE:  next_rdata[0] = fifo_control_reg[`UIT_FCR_EN];
				REG_SRT:  next_rdata[1:0] =
					fifo_control_reg[`UIT_FCR_RT_HI:`UIT_FCR_RT_LO];
				REG_STER: next_rdata[1:0] =
					fifo_control_reg[`UIT_FCR_TET_HI:`UIT_FCR_TET_LO];
				default:  next_rresp = `UIT_RESP_SLVERR;
			endcase
		end
	end

	// Next values of event flags and the timeout counter
	always_comb
	begin
		// Line errors: a new error wins over the status read
		next_err = err & ~{4{do_rd && rd_sel == REG_LSR}};
		next_err = next_err | {rx_valid && rx_break,
			rx_valid && rx_frame_err, rx_valid && rx_parity_err,
			rx_valid && rx_full_eff};
		// Transmit-empty event: set on entry or on enabling, set wins
		next_tx_holding_empty_pend = tx_holding_empty_pend;
		if ((do_rd && rd_sel == REG_IIR && id == `UIT_ID_TX_HOLDING_EMPTY)
			|| txf.push || !tx_holding_empty_cond)
			next_tx_holding_empty_pend = 1'b0;
		if (tx_holding_empty_cond && (!tx_holding_empty_cond_q
			|| (irq_enable_reg[`UIT_IER_TX_HOLDING_EMPTY] && !tx_holding_empty_en_q)))
			next_tx_holding_empty_pend = 1'b1;
		// Any receive activity or an empty FIFO restarts the count
		if (rxf.push || rxf.pop || rxf.empty)
			next_tmo_cnt = '0;
		else if (baud_tick && tmo_cnt != TW'(TMO_TICKS))
			next_tmo_cnt = TW'(tmo_cnt + 1'b1);
		else
			next_tmo_cnt = tmo_cnt;
	end

	// Register all state; a low clock enable freezes it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			irq_enable_reg         <= `UIT_IER_RST;
			fifo_control_reg         <= `UIT_FCR_RST;
			err         <= '0;
			tx_holding_empty_pend   <= 1'b0;
			tx_holding_empty_cond_q <= 1'b0;
			tx_holding_empty_en_q   <= 1'b0;
			tmo_cnt     <= '0;
			irq_q       <= 1'b0;
			aw_held     <= 1'b0;
			aw_addr     <= '0;
			w_held      <= 1'b0;
			w_byte      <= '0;
			w_lane0     <= 1'b0;
			bvalid_q    <= 1'b0;
			bresp_q     <= `UIT_RESP_OKAY;
			rvalid_q    <= 1'b0;
			rdata_q     <= '0;
			rresp_q     <= `UIT_RESP_OKAY;
		end
		else if (ce)
		begin
			irq_enable_reg         <= next_ier;
			fifo_control_reg         <= next_fcr;
			err         <= next_err;
			tx_holding_empty_pend   <= next_tx_holding_empty_pend;
			tx_holding_empty_cond_q <= tx_holding_empty_cond;
			tx_holding_empty_en_q   <= irq_enable_reg[`UIT_IER_TX_HOLDING_EMPTY];
			tmo_cnt     <= next_tmo_cnt;
			irq_q       <= line_act || rda_act || tmo_act
				|| tx_holding_empty_act;
			aw_held     <= next_aw_held;
			aw_addr     <= next_aw_addr;
			w_held      <= next_w_held;
			w_byte      <= next_w_byte;
			w_lane0     <= next_w_lane0;
			bvalid_q    <= next_bvalid;
			bresp_q     <= next_bresp;
			rvalid_q    <= next_rvalid;
			rdata_q     <= next_rdata;
			rresp_q     <= next_rresp;
		end
	end
	assign irq = irq_q;

endmodule // uit_uart_irq
`default_nettype wire

// *** include/uit_defines.svh ***
// Named constants of the interrupt, threshold and shadow block of the UART.
// Included by the top and priority design files; definitions only.
`ifndef UIT_DEFINES_SVH
`define UIT_DEFINES_SVH

// Bus address width and register byte offsets
`define UIT_AW             8
`define UIT_OFF_DATA       8'h00
`define UIT_OFF_IER        8'h04
`define UIT_OFF_IIR        8'h08
`define UIT_OFF_LSR        8'h14
`define UIT_OFF_SHADOW_LO  8'h30
`define UIT_OFF_SHADOW_HI  8'h6c
`define UIT_OFF_SFE        8'h88
`define UIT_OFF_SRT        8'h8c
`define UIT_OFF_STER       8'h90

// Enable register fields
`define UIT_IER_RDA        0
`define UIT_IER_TX_HOLDING_EMPTY       1
`define UIT_IER_LINE       2
`define UIT_IER_PROG       7
`define UIT_IER_RST        8'h00

// FIFO control fields
`define UIT_FCR_EN         0
`define UIT_FCR_RXRST      1
`define UIT_FCR_TXRST      2
`define UIT_FCR_TET_LO     4
`define UIT_FCR_TET_HI     5
`define UIT_FCR_RT_LO      6
`define UIT_FCR_RT_HI      7
`define UIT_FCR_RST        8'h00

// Threshold and trigger selections
`define UIT_SEL_0          2'h0
`define UIT_SEL_1          2'h1
`define UIT_SEL_2          2'h2
`define UIT_SEL_3          2'h3
`define UIT_TET_TWO_LEVEL  2
`define UIT_RT_FULL_GAP    2

// Line status fields
`define UIT_LSR_DR         0
`define UIT_LSR_OE         1
`define UIT_LSR_PE         2
`define UIT_LSR_FE         3
`define UIT_LSR_BI         4
`define UIT_LSR_TX_HOLDING_EMPTY       5
`define UIT_LSR_TEMT       6
`define UIT_LSR_RFE        7

// Identification codes and FIFO flag field
`define UIT_ID_NONE        4'h1
`define UIT_ID_LINE        4'h6
`define UIT_ID_RDA         4'h4
`define UIT_ID_TMO         4'hc
`define UIT_ID_TX_HOLDING_EMPTY        4'h2
`define UIT_IIR_FIFO_ON    2'h3
`define UIT_IIR_FIFO_OFF   2'h0

// Character timing
`define UIT_BAUD_PER_BIT   16
`define UIT_TMO_CHARS      4

// Bus responses
`define UIT_RESP_OKAY      2'h0
`define UIT_RESP_SLVERR    2'h2

`endif

// *** include/uit_pkg.sv ***
// Types shared by the UART interrupt block.
// Assumes nothing beyond a SystemVerilog compiler.
package uit_pkg;
	typedef logic [7:0] uit_byte_t;    // Character or register byte
	typedef logic [3:0] uit_id_t;      // Identification code
	typedef logic [1:0] uit_resp_t;    // Bus response code
	// Register selected by a bus address
	typedef enum {
		REG_DATA, REG_IER, REG_IIR, REG_LSR,
		REG_SFE, REG_SRT, REG_STER, REG_NONE
	} uit_reg_e;
endpackage

// *** include/uit_fifo_if.sv ***
// Carrier between the UART block and one of its character FIFOs.
// Assumes one clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface uit_fifo_if #(
	parameter int W     = 8,
	parameter int DEPTH = 16,
	parameter int CW    = $clog2(DEPTH + 1)
);
	logic          push;       // Store push_data
	logic [W-1:0]  push_data;  // Character in
	logic          pop;        // Drop head
	logic [W-1:0]  pop_data;   // Head character
	logic [CW-1:0] count;      // Fill level
	logic          full;       // No room
	logic          empty;      // Nothing held
	logic          flush;      // Discard all

	modport fifo (input push, push_data, pop, flush,
		output pop_data, count, full, empty);
	modport user (output push, push_data, pop, flush,
		input pop_data, count, full, empty);
endinterface
`default_nettype wire

// *** rtl/uit_fifo.sv ***
// Character FIFO in flip-flops, used for receive and transmit.
// Assumes DEPTH is a power of two; push when full and pop when empty
// are ignored.
`timescale 1ns/100ps
`default_nettype none
module uit_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	uit_fifo_if.fifo  f
);
	import uit_pkg::*;
	localparam int IW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem [DEPTH];   // Storage
	logic [IW-1:0] wptr;          // Write index
	logic [IW-1:0] rptr;          // Read index
	logic [CW-1:0] count;         // Fill level
	logic [IW-1:0] next_wptr;
	logic [IW-1:0] next_rptr;
	logic [CW-1:0] next_count;
	logic          do_push;
	logic          do_pop;

	assign f.pop_data = mem[rptr];
	assign f.count    = count;
	assign f.full     = (count == CW'(DEPTH));
	assign f.empty    = (count == '0);

	// Pointer and level updates
	always_comb
	begin
		do_push    = f.push && !f.full;
		do_pop     = f.pop && !f.empty;
		next_wptr  = do_push ? IW'(wptr + 1'b1) : wptr;
		next_rptr  = do_pop ? IW'(rptr + 1'b1) : rptr;
		next_count = CW'(count + CW'(do_push) - CW'(do_pop));
		if (f.flush)
		begin
			next_wptr  = '0;
			next_rptr  = '0;
			next_count = '0;
		end
	end

	// Register pointers, level and storage
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wptr  <= '0;
			rptr  <= '0;
			count <= '0;
		end
		else if (ce)
		begin
			wptr  <= next_wptr;
			rptr  <= next_rptr;
			count <= next_count;
			if (do_push && !f.flush)
				mem[wptr] <= f.push_data;
		end
	end
endmodule // uit_fifo
`default_nettype wire

// *** rtl/uit_irq_prio.sv ***
// Priority encoder from enabled active sources to identification code.
// Assumes each input already includes its enable.
`timescale 1ns/100ps
`default_nettype none
`include "uit_defines.svh"
module uit_irq_prio (
	input  wire logic     line_act,
	input  wire logic     rda_act,
	input  wire logic     tmo_act,
	input  wire logic     tx_holding_empty_act,
	output uit_pkg::uit_id_t id
);
	import uit_pkg::*;

	// Highest pending source wins; only documented codes can appear
	always_comb
	begin
		if (line_act)
			id = `UIT_ID_LINE;
		else if (rda_act)
			id = `UIT_ID_RDA;
		else if (tmo_act)
			id = `UIT_ID_TMO;
		else if (tx_holding_empty_act)
			id = `UIT_ID_TX_HOLDING_EMPTY;
		else
			id = `UIT_ID_NONE;
	end
endmodule // uit_irq_prio
`default_nettype wire

// *** verif/uit_uart_irq_chk.sv ***
// Checker for the UART interrupt block, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module uit_uart_irq_chk (
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire logic               awvalid,
	input wire logic               awready,
	input wire logic               wvalid,
	input wire logic               wready,
	input wire logic               bvalid,
	input wire logic               bready,
	input wire uit_pkg::uit_resp_t bresp,
	input wire logic [7:0]         araddr,
	input wire logic               arvalid,
	input wire logic               arready,
	input wire logic [31:0]        rdata,
	input wire logic               rvalid,
	input wire logic               rready,
	input wire logic               tx_valid,
	input wire uit_pkg::uit_byte_t tx_data,
	input wire logic               tx_ready
);
	import uit_pkg::*;
	logic [7:0] ra;      // Address of the read under way
	logic [7:0] next_ra; // Captured when the read is taken
	// Hold the read address while its answer stands
	always_comb next_ra = (arvalid && arready) ? araddr : ra;
	always_ff @(posedge aclk) ra <= next_ra;
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken; awvalid && awready && wvalid && wready; endsequence
	sequence s_rd_taken; arvalid && arready; endsequence
	property p_wr_ans; s_wr_taken |-> ##[1:2] bvalid; endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
	property p_rd_ans; s_rd_taken |=> rvalid; endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
	property p_busy; bvalid |-> !awready && !wready; endproperty
	a_busy: assert property (p_busy) else $error("write taken while busy");
	property p_tx_hold; tx_valid && !tx_ready |=>
		$rose(bvalid) || (tx_valid && $stable(tx_data)); endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx head moved");
	property p_id_rsv; rvalid && ra == 8'h08 |-> rdata[3:0] != 4'h0
		&& rdata[3:0] != 4'h7 && rdata[5:4] == 2'h0; endproperty
	a_id_rsv: assert property (p_id_rsv) else $error("bad ident");
	property p_sfe; rvalid && ra == 8'h88 |-> rdata[31:1] == 31'h0; endproperty
	a_sfe: assert property (p_sfe) else $error("sfe wide");
	property p_srt; rvalid && ra == 8'h8c |-> rdata[31:2] == 30'h0; endproperty
	a_srt: assert property (p_srt) else $error("srt wide");
	property p_ster; rvalid && ra == 8'h90 |-> rdata[31:2] == 30'h0;
	endproperty
	a_ster: assert property (p_ster) else $error("ster wide");
endmodule // uit_uart_irq_chk
bind uit_uart_irq uit_uart_irq_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .bresp(bresp), .araddr(araddr),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
	.rready(rready), .tx_valid(tx_valid), .tx_data(tx_data),
	.tx_ready(tx_ready));
`default_nettype wire

// *** verif/uit_serial_model.sv ***
// Serial side model: hands in characters, takes transmit characters.
// Assumes the bench calls send and drives stall.
`timescale 1ns/100ps
`default_nettype none
module uit_serial_model (
	input wire logic          aclk,
	input wire logic          stall,
	input wire logic          tx_valid,
	input wire uit_pkg::uit_byte_t tx_data,
	output logic              tx_ready,
	output logic              tx_idle,
	output logic              rx_valid,
	output logic              rx_parity_err,
	output logic              rx_frame_err,
	output logic              rx_break,
	output logic              baud_tick,
	output uit_pkg::uit_byte_t rx_data,
	output uit_pkg::uit_byte_t last
);
	import uit_pkg::*;
	// Quiet line at time zero
	initial
	begin
		{rx_valid, rx_parity_err, rx_frame_err, rx_break} = 4'h0;
		{baud_tick, tx_idle, rx_data, last} = 18'h1_00_00;
	end
	// Baud pulse every other cycle, well inside the rate limit
	always @(posedge aclk) baud_tick <= ~baud_tick;
	assign tx_ready = !stall;
	// Record each character taken from the transmit side
	always @(posedge aclk)
	begin
		if (tx_valid && tx_ready) last <= tx_data;
		tx_idle <= !(tx_valid && tx_ready);
	end
	// One received character; e is {break, framing, parity}
	task automatic send(input uit_byte_t d, input logic [2:0] e);
		@(posedge aclk);
		{rx_valid, rx_data} <= {1'b1, d};
		{rx_break, rx_frame_err, rx_parity_err} <= e;
		@(posedge aclk);
		{rx_valid, rx_data} <= {1'b0, ~d};
		{rx_break, rx_frame_err, rx_parity_err} <= 3'h0;
	endtask
endmodule // uit_serial_model
`default_nettype wire

// *** verif/tb_uit_uart_irq.sv ***
// Bench for the UART interrupt block over AXI4-Lite.
// Assumes the serial model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_uit_uart_irq;
	import uit_pkg::*;
	logic aclk = 0, aresetn = 0, stall = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rd_d;
	logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready;
	logic tx_idle, rx_valid, rx_pe, rx_fe, rx_bk, baud_tick, irq;
	uit_byte_t rx_data, tx_data, last;
	uit_resp_t bresp, rresp, br, rr;
	int num_errors = 0, cmp_count = 0, i;
	always #2.5 aclk = ~aclk;
	uit_uart_irq DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_parity_err(rx_pe), .rx_frame_err(rx_fe), .rx_break(rx_bk),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.tx_idle(tx_idle), .baud_tick(baud_tick), .irq(irq));
	uit_serial_model PM (.aclk(aclk), .stall(stall), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .tx_idle(tx_idle),
		.rx_valid(rx_valid), .rx_parity_err(rx_pe), .rx_frame_err(rx_fe),
		.rx_break(rx_bk), .baud_tick(baud_tick), .rx_data(rx_data),
		.last(last));
	// Verdict and end of run
	task give_verdict;
		if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h, want %h", $time, g, e);
		end
	endtask
	// Register write; waits for the response under a bound
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		logic ta, tw, tb;
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'h7};
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			{ta, tw, tb, br} = {awvalid & awready, wvalid & wready,
				bready & bvalid, bresp};
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			if (tb) break;
		end
		if (n == 50)
		begin
			num_errors++;
			give_verdict();
		end
	endtask
	// Register read into rd_d and rr
	task automatic rd(input logic [7:0] a);
		int n;
		logic ta, tr;
		@(posedge aclk);
		{araddr, arvalid, rready} <= {a, 2'h3};
		for (n = 0; n < 50; n++)
		begin
			@(negedge aclk);
			{ta, tr, rd_d, rr} = {arvalid & arready, rvalid & rready, rdata, rresp};
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
			if (tr) break;
		end
		if (n == 50)
		begin
			num_errors++;
			give_verdict();
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_d, e);
	endtask
	// Main sequence
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(8'h08, 32'h01);
		wr(8'h04, 8'h02);
		rc(8'h08, 32'h02);
		rc(8'h08, 32'h01);
		@(negedge aclk);
		chk(irq, 1'b0);
		wr(8'h04, 8'h05);
		PM.send(8'h5a, 3'h7);
		PM.send(8'h11, 3'h0);
		repeat (3) @(negedge aclk);
		chk(irq, 1'b1);
		rc(8'h08, 32'h06);
		rc(8'h14, 32'h7f);
		rc(8'h08, 32'h04);
		rc(8'h30, 32'h5a);
		rc(8'h08, 32'h01);
		wr(8'h88, 8'h01);
		repeat (8) @(posedge aclk);
		wr(8'h90, 8'h03);
		wr(8'h8c, 8'h01);
		rc(8'h88, 32'h1);
		rc(8'h8c, 32'h1);
		rc(8'h90, 32'h3);
		PM.send(8'h33, 3'h0);
		rc(8'h08, 32'hc1);
		repeat (1500) @(posedge aclk);
		rc(8'h08, 32'hcc);
		rc(8'h00, 32'h33);
		rc(8'h08, 32'hc1);
		stall <= 1'b1;
		wr(8'h90, 8'h01);
		wr(8'h04, 8'h82);
		rc(8'h08, 32'hc2);
		for (i = 0; i < 16; i++)
		begin
			wr(8'(8'h30 + 4 * i), 8'(i));
			if (i == 2) rc(8'h08, 32'hc1);
		end
		rd(8'h14);
		chk(rd_d[5], 1'b1);
		stall <= 1'b0;
		repeat (40) @(posedge aclk);
		chk(last, 8'h0f);
		rc(8'h08, 32'hc2);
		wr(8'h88, 8'h00);
		stall <= 1'b1;
		wr(8'h00, 8'h77);
		rc(8'h08, 32'h01);
		rd(8'h14);
		chk(rd_d[5], 1'b0);
		stall <= 1'b0;
		repeat (10) @(posedge aclk);
		rc(8'h08, 32'h02);
		chk(last, 8'h77);
		rc(8'hfc, 32'h0);
		chk(rr, 2'h2);
		wr(8'hfc, 8'h01);
		chk(br, 2'h2);
		give_verdict();
	end
endmodule // tb_uit_uart_irq
`default_nettype wire
